// ### core/dsa_core.sv
// Purpose: Execution slice: OR, port output, product move, stack, returns,
//          status clears, rotates, repeat and stores
// Assumes: Decoder supplies memory operand, aux value and condition result
// Notes: Stores and port writes run an external write cycle held to ready
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module dsa_core
    import dsa_pkg::*;
#(
    parameter int STACK_DEPTH = STACK_DEPTH_DEF
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire dsa_cmd_t cmd,
    output logic cmd_ready,
    input wire logic bus_ready,
    output dsa_bus_t bus,
    output logic external_flag,
    output logic pc_load,
    output logic [AW-1:0] program_counter,
    input wire logic [RA_W-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        dsa_state_t st;
        logic [31:0] acc;
        logic [31:0] prod;
        logic carry;
        logic test_flag;
        logic overflow_mode_bit;
        logic sign_extend_mode;
        logic xf;
        logic [1:0] product_shift_mode;
        logic [DW-1:0] repeat_counter;
        dsa_cmd_t held;
        dsa_bus_t bus;
        logic pc_load;
        logic [AW-1:0] pc;
        logic ready;
        logic [DW-1:0] rdata;
    } dsa_core_state_t;

    dsa_core_state_t s_ff;
    dsa_core_state_t nxt_s;
    logic go;
    dsa_cmd_t c;
    logic push;
    logic pop;
    logic [DW-1:0] push_data;
    logic [DW-1:0] stack_top;
    logic [31:0] prod_shifted;
    logic [31:0] or_operand;
    logic [31:0] store_copy;
    logic [DW-1:0] status_word;

    dsa_stack #(.DEPTH(STACK_DEPTH)) u_stack (
        .clk(clk),
        .rst_n(rst_n),
        .push(push),
        .pop(pop),
        .push_data(push_data),
        .top(stack_top)
    );

    dsa_prod_shift u_pshift (
        .prod(s_ff.prod),
        .product_shift_mode(s_ff.product_shift_mode),
        .shifted(prod_shifted)
    );

    always_comb
    begin
        status_word = '0;
        status_word[ST_CARRY] = s_ff.carry;
        status_word[ST_TEST] = s_ff.test_flag;
        status_word[ST_OVM] = s_ff.overflow_mode_bit;
        status_word[ST_SXM] = s_ff.sign_extend_mode;
        status_word[ST_XF] = s_ff.xf;
        status_word[ST_PM_LO +: 2] = s_ff.product_shift_mode;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.pc_load = 1'b0;
        push = 1'b0;
        pop = 1'b0;
        push_data = '0;
        go = 1'b0;
        c = cmd;
        case (s_ff.st)
            ST_IDLE:
                go = cmd_valid;
            ST_REPEAT:
            begin
                go = 1'b1;
                c = s_ff.held;
            end
            ST_BUS:
                if (bus_ready)
                begin
                    // Write cycle ends on ready, exactly like memory writes
                    nxt_s.bus.strobe_n = 1'b1;
                    nxt_s.bus.rw_n = 1'b1;
                    nxt_s.bus.io_space_select_n = 1'b1;
                    nxt_s.st = (s_ff.repeat_counter != '0) ? ST_REPEAT
                                                            : ST_IDLE;
                end
            default:
                nxt_s.st = ST_IDLE;
        endcase

        // Operand shifted within a 32-bit field; outside bits stay zero
        or_operand = {16'h0000, (c.op == OP_OR_IMM) ? c.imm : c.mem_data}
                     << c.shift;
        store_copy = s_ff.acc << c.shift[2:0];

        if (go)
        begin
            // Repeat bookkeeping: the current run plus counter more runs
            if (s_ff.st == ST_REPEAT)
                nxt_s.repeat_counter = s_ff.repeat_counter - 16'h0001;
            else
                nxt_s.held = c;
            nxt_s.st = (nxt_s.repeat_counter != '0) ? ST_REPEAT : ST_IDLE;
            nxt_s.bus.addr = c.addr;
            nxt_s.bus.io_space_select_n = 1'b1;
            case (c.op)
                OP_OR_MEM, OP_OR_IMM:
                    nxt_s.acc = s_ff.acc | or_operand;
                OP_PORT_WRITE:
                begin
                    nxt_s.bus.data = c.mem_data;
                    nxt_s.bus.io_space_select_n = 1'b0;
                end
                OP_PRODUCT_TO_ACC:
                    nxt_s.acc = prod_shifted;
                OP_STACK_TO_LOW_ACC:
                begin
                    nxt_s.acc = {16'h0000, stack_top};
                    pop = 1'b1;
                end
                OP_STACK_TO_MEM:
                begin
                    nxt_s.bus.data = stack_top;
                    pop = 1'b1;
                end
                OP_MEM_ONTO_STACK:
                begin
                    push = 1'b1;
                    push_data = c.mem_data;
                end
                OP_LOW_ACC_ONTO_STACK:
                begin
                    push = 1'b1;
                    push_data = s_ff.acc[15:0];
                end
                OP_SUB_EXIT, OP_COND_EXIT:
                    // Decoder folds every listed condition into cond_met
                    if (c.op == OP_SUB_EXIT || c.cond_met)
                    begin
                        nxt_s.pc = stack_top;
                        nxt_s.pc_load = 1'b1;
                        pop = 1'b1;
                    end
                OP_CLR_CARRY:
                    nxt_s.carry = 1'b0;
                OP_CLR_TEST:
                    nxt_s.test_flag = 1'b0;
                OP_CLR_OVM:
                    nxt_s.overflow_mode_bit = 1'b0;
                OP_CLR_SXM:
                    nxt_s.sign_extend_mode = 1'b0;
                OP_CLR_XF:
                    nxt_s.xf = 1'b0;
                OP_ROT_LEFT:
                    {nxt_s.carry, nxt_s.acc} = {s_ff.acc, s_ff.carry};
                OP_ROT_RIGHT:
                    {nxt_s.acc, nxt_s.carry} = {s_ff.carry, s_ff.acc};
                OP_RPT_MEM:
                    nxt_s.repeat_counter = {8'h00, c.mem_data[7:0]};
                OP_RPT_IMM:
                    nxt_s.repeat_counter = c.imm;
                OP_RPT_SHORT:
                    nxt_s.repeat_counter = {8'h00, c.imm[7:0]};
                OP_STORE_HIGH:
                    nxt_s.bus.data = store_copy[31:16];
                OP_STORE_LOW:
                    nxt_s.bus.data = store_copy[15:0];
                OP_STORE_AUX:
                    nxt_s.bus.data = c.aux_value;
                default:
                    nxt_s.acc = s_ff.acc;
            endcase
            // A repeat load never counts as a repeated instruction
            if (c.op == OP_RPT_MEM || c.op == OP_RPT_IMM ||
                c.op == OP_RPT_SHORT)
                nxt_s.st = ST_IDLE;
            case (c.op)
                OP_PORT_WRITE, OP_STACK_TO_MEM, OP_STORE_HIGH,
                OP_STORE_LOW, OP_STORE_AUX:
                begin
                    nxt_s.st = ST_BUS;
                    nxt_s.bus.strobe_n = 1'b0;
                    nxt_s.bus.rw_n = 1'b0;
                end
                default:
                    nxt_s.bus.strobe_n = 1'b1;
            endcase
        end

        // Register port; software writes land after the instruction
        if (reg_wr)
        begin
            case (reg_addr)
                REG_ACC_LO: nxt_s.acc[15:0] = reg_wdata;
                REG_ACC_HI: nxt_s.acc[31:16] = reg_wdata;
                REG_PROD_LO: nxt_s.prod[15:0] = reg_wdata;
                REG_PROD_HI: nxt_s.prod[31:16] = reg_wdata;
                REG_STATUS:
                begin
                    nxt_s.carry = reg_wdata[ST_CARRY];
                    nxt_s.test_flag = reg_wdata[ST_TEST];
                    nxt_s.overflow_mode_bit = reg_wdata[ST_OVM];
                    nxt_s.sign_extend_mode = reg_wdata[ST_SXM];
                    nxt_s.xf = reg_wdata[ST_XF];
                    nxt_s.product_shift_mode = reg_wdata[ST_PM_LO +: 2];
                end
                default: nxt_s.rdata = s_ff.rdata;
            endcase
        end
        nxt_s.rdata = '0;
        if (reg_rd)
        begin
            case (reg_addr)
                REG_ACC_LO: nxt_s.rdata = s_ff.acc[15:0];
                REG_ACC_HI: nxt_s.rdata = s_ff.acc[31:16];
                REG_PROD_LO: nxt_s.rdata = s_ff.prod[15:0];
                REG_PROD_HI: nxt_s.rdata = s_ff.prod[31:16];
                REG_STATUS: nxt_s.rdata = status_word;
                REG_RPT: nxt_s.rdata = s_ff.repeat_counter;
                REG_STACK_TOP: nxt_s.rdata = stack_top;
                REG_PC: nxt_s.rdata = s_ff.pc;
                default: nxt_s.rdata = '0;
            endcase
        end
        nxt_s.ready = (nxt_s.st == ST_IDLE);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_ff <= '0;
            s_ff.st <= ST_IDLE;
            s_ff.carry <= RST_CARRY;
            s_ff.test_flag <= RST_TEST;
            s_ff.overflow_mode_bit <= RST_OVM;
            s_ff.sign_extend_mode <= RST_SXM;
            s_ff.xf <= RST_XF;
            s_ff.product_shift_mode <= RST_PM;
            s_ff.bus.strobe_n <= 1'b1;
            s_ff.bus.rw_n <= 1'b1;
            s_ff.bus.io_space_select_n <= 1'b1;
            s_ff.ready <= 1'b1;
        end
        else
            s_ff <= nxt_s;
    end

    assign cmd_ready = s_ff.ready;
    assign bus = s_ff.bus;
    assign external_flag = s_ff.xf;
    assign pc_load = s_ff.pc_load;
    assign program_counter = s_ff.pc;
    assign reg_rdata = s_ff.rdata;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_short_rpt_one;
        go && c.op == OP_RPT_SHORT && c.imm == 16'h0001;
    endsequence
    sequence s_plain_issue;
        cmd_valid && cmd_ready && cmd.op == OP_CLR_TEST;
    endsequence

    a_repeat_twice: assert property (@(posedge clk) disable iff (!rst_n)
        s_short_rpt_one ##[1:2] s_plain_issue |=> s_ff.st == ST_REPEAT ##1
        s_ff.st == ST_IDLE)
        else $error("repeated instruction did not run count plus one");
    a_port_cycle: assert property (@(posedge clk) disable iff (!rst_n)
        go && c.op == OP_PORT_WRITE |=> !bus.strobe_n && !bus.rw_n &&
        !bus.io_space_select_n && bus.data == $past(c.mem_data))
        else $error("port write cycle malformed");
    a_strobe_hold: assert property (@(posedge clk) disable iff (!rst_n)
        !bus.strobe_n && !bus_ready |=> !bus.strobe_n)
        else $error("strobe released before ready");
    a_exit_pc: assert property (@(posedge clk) disable iff (!rst_n)
        go && c.op == OP_SUB_EXIT |=> pc_load &&
        program_counter == $past(stack_top))
        else $error("return did not load the stack top");
    a_cond_skip: assert property (@(posedge clk) disable iff (!rst_n)
        go && c.op == OP_COND_EXIT && !c.cond_met |=> !pc_load)
        else $error("conditional exit taken with false condition");
    a_rotate_left: assert property (@(posedge clk) disable iff (!rst_n)
        go && c.op == OP_ROT_LEFT && !reg_wr |=>
        s_ff.acc == {$past(s_ff.acc[30:0]), $past(s_ff.carry)} &&
        s_ff.carry == $past(s_ff.acc[31]))
        else $error("rotate left through carry wrong");
    a_xf_clear: assert property (@(posedge clk) disable iff (!rst_n)
        go && c.op == OP_CLR_XF && !reg_wr |=> !external_flag)
        else $error("external flag pin not cleared");
    a_pac_load: assert property (@(posedge clk) disable iff (!rst_n)
        go && c.op == OP_PRODUCT_TO_ACC && !reg_wr |=>
        s_ff.acc == $past(prod_shifted))
        else $error("product move ignored shift mode");
    a_pop_upper: assert property (@(posedge clk) disable iff (!rst_n)
        go && c.op == OP_STACK_TO_LOW_ACC && !reg_wr |=>
        s_ff.acc == {16'h0000, $past(stack_top)})
        else $error("stack to accumulator did not clear upper half");
    a_store_high: assert property (@(posedge clk) disable iff (!rst_n)
        go && c.op == OP_STORE_HIGH |=>
        bus.data == $past(store_copy[31:16]) && !bus.rw_n)
        else $error("store high wrote wrong word");

endmodule
`default_nettype wire

// ### core/dsa_pkg.sv
// Purpose: Shared types and constants of the accumulator/stack execution slice
// Assumes: 16-bit data words, 32-bit accumulator and product register
// Notes: Register map is reached through a plain strobe port
package dsa_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int DW = 16;
    localparam int AW = 16;
    localparam int RA_W = 4;
    localparam int STACK_DEPTH_DEF = 8;

    // ************************************************************
    // Register map (word index on the register port)
    // ************************************************************
    localparam logic [RA_W-1:0] REG_ACC_LO = 4'h0;
    localparam logic [RA_W-1:0] REG_ACC_HI = 4'h1;
    localparam logic [RA_W-1:0] REG_PROD_LO = 4'h2;
    localparam logic [RA_W-1:0] REG_PROD_HI = 4'h3;
    localparam logic [RA_W-1:0] REG_STATUS = 4'h4;
    localparam logic [RA_W-1:0] REG_RPT = 4'h5;
    localparam logic [RA_W-1:0] REG_STACK_TOP = 4'h6;
    localparam logic [RA_W-1:0] REG_PC = 4'h7;

    // ************************************************************
    // Status field positions and reset values
    // ************************************************************
    localparam int ST_CARRY = 0;
    localparam int ST_TEST = 1;
    localparam int ST_OVM = 2;
    localparam int ST_SXM = 3;
    localparam int ST_XF = 4;
    localparam int ST_PM_LO = 5;
    localparam logic RST_CARRY = 1'b0;
    localparam logic RST_TEST = 1'b0;
    localparam logic RST_OVM = 1'b0;
    localparam logic RST_SXM = 1'b1;
    localparam logic RST_XF = 1'b1;
    localparam logic [1:0] RST_PM = 2'h0;

    // Product shift codes
    localparam logic [1:0] PM_NONE = 2'h0;
    localparam logic [1:0] PM_LEFT1 = 2'h1;
    localparam logic [1:0] PM_LEFT4 = 2'h2;
    localparam int PM_RIGHT_AMT = 6;
    localparam int PM_LEFT_AMT = 4;

    typedef enum logic [4:0] {
        OP_NOP, OP_OR_MEM, OP_OR_IMM, OP_PORT_WRITE, OP_PRODUCT_TO_ACC,
        OP_STACK_TO_LOW_ACC, OP_STACK_TO_MEM, OP_MEM_ONTO_STACK,
        OP_LOW_ACC_ONTO_STACK, OP_SUB_EXIT, OP_COND_EXIT, OP_CLR_CARRY,
        OP_CLR_TEST, OP_CLR_OVM, OP_CLR_SXM, OP_CLR_XF, OP_ROT_LEFT,
        OP_ROT_RIGHT, OP_RPT_MEM, OP_RPT_IMM, OP_RPT_SHORT,
        OP_STORE_HIGH, OP_STORE_LOW, OP_STORE_AUX
    } dsa_op_t;

    typedef enum logic [1:0] {ST_IDLE, ST_BUS, ST_REPEAT} dsa_state_t;

    // One decoded instruction from fetch/decode
    typedef struct packed {
        dsa_op_t op;
        logic [DW-1:0] mem_data;
        logic [DW-1:0] imm;
        logic [DW-1:0] aux_value;
        logic [3:0] shift;
        logic [AW-1:0] addr;
        logic cond_met;
    } dsa_cmd_t;

    // External write cycle, strobes active low
    typedef struct packed {
        logic strobe_n;
        logic rw_n;
        logic io_space_select_n;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
    } dsa_bus_t;

endpackage

// ### core/dsa_prod_shift.sv
// Purpose: Product register output shifter
// Assumes: Two-bit product_shift_mode code
// Notes: Pure combinational
`timescale 1ns/1ns
`default_nettype none
module dsa_prod_shift
    import dsa_pkg::*;
(
    input wire logic [31:0] prod,
    input wire logic [1:0] product_shift_mode,
    output logic [31:0] shifted
);
    always_comb
    begin
        case (product_shift_mode)
            PM_NONE: shifted = prod;
            PM_LEFT1: shifted = {prod[30:0], 1'b0};
            PM_LEFT4: shifted = prod << PM_LEFT_AMT;
            default: shifted = $signed(prod) >>> PM_RIGHT_AMT;
        endcase
    end
endmodule
`default_nettype wire

// ### core/dsa_stack.sv
// Purpose: Hardware return/data stack
// Assumes: Push and pop never in the same cycle
// Notes: Bottom level copies into itself on pop, as usual for such stacks
`timescale 1ns/1ns
`default_nettype none
module dsa_stack
    import dsa_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH_DEF
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic pop,
    input wire logic [DW-1:0] push_data,
    output logic [DW-1:0] top
);
    logic [DW-1:0] lvl_ff [DEPTH];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            lvl_ff[0] <= '0;
        else if (push)
            lvl_ff[0] <= push_data;
        else if (pop)
            lvl_ff[0] <= lvl_ff[1];
    end

    genvar i;
    generate
        for (i = 1; i < DEPTH; i++)
        begin : g_lvl
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    lvl_ff[i] <= '0;
                else if (push)
                    lvl_ff[i] <= lvl_ff[i-1];
                else if (pop && i < DEPTH - 1)
                    lvl_ff[i] <= lvl_ff[(i + 1) % DEPTH];
            end
        end
    endgenerate

    assign top = lvl_ff[0];
endmodule
`default_nettype wire

// ### testbench/dsa_bus_model.sv
// Purpose: Far-side memory and I/O bus responder
// Assumes: Write cycles only; strobe and rw active low
// Notes: Waits 0 to 2 cycles before ready, to vary the handshake
`timescale 1ns/1ns
`default_nettype none
module dsa_bus_model
    import dsa_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire dsa_bus_t bus,
    output logic bus_ready,
    output logic seen,
    output dsa_bus_t seen_bus
);
    int wait_n;
    // ****
    // Ready handshake
    // ****
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_ready <= 1'b0;
            seen <= 1'b0;
            seen_bus <= '0;
            wait_n <= 0;
        end
        else
        begin
            seen <= 1'b0;
            // Ready drops right after the accepting edge
            if (bus_ready && !bus.strobe_n)
            begin
                bus_ready <= 1'b0;
                seen <= 1'b1;
                seen_bus <= bus;
                wait_n <= $urandom_range(2);
            end
            else if (!bus.strobe_n)
            begin
                if (wait_n == 0)
                    bus_ready <= 1'b1;
                else
                    wait_n <= wait_n - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### testbench/test_dsa_core.sv
// Purpose: Self-checking bench of the execution slice
// Assumes: Bus responder model on the external write port
// Notes: Expected results queue up; a watcher pops them as outputs appear
`timescale 1ns/1ns
`default_nettype none
module test_dsa_core;
    import dsa_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    dsa_cmd_t cmd = '0;
    logic cmd_ready, bus_ready, external_flag, pc_load, seen;
    logic [RA_W-1:0] reg_addr = '0;
    logic [DW-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic [DW-1:0] reg_rdata, d;
    logic [AW-1:0] program_counter;
    dsa_bus_t bus, seen_bus;
    logic [DW-1:0] word_q[$];
    logic [DW-1:0] pc_q[$];
    dsa_bus_t bus_q[$];
    logic [31:0] acc, p;
    logic [15:0] st;
    logic [3:0] sh;
    dsa_op_t bops[4] = '{OP_PORT_WRITE, OP_STORE_HIGH, OP_STORE_LOW,
        OP_STORE_AUX};
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int i;

    dsa_core dsa_core_i (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .bus_ready(bus_ready), .bus(bus),
        .external_flag(external_flag), .pc_load(pc_load),
        .program_counter(program_counter), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    dsa_bus_model dsa_bus_model_i (.clk(clk), .rst_n(rst_n), .bus(bus),
        .bus_ready(bus_ready), .seen(seen), .seen_bus(seen_bus));

    initial forever #4 clk = ~clk;

    // ****
    // Tasks
    // ****
    task automatic fail_msg(input string m);
        fail_count++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask
    task automatic chk_word(input logic [DW-1:0] e, input logic [DW-1:0] g);
        num_checks++;
        if (g !== e)
            fail_msg($sformatf("word %h, expected %h", g, e));
    endtask
    task automatic chk_bus(input dsa_bus_t e, input dsa_bus_t g);
        num_checks++;
        if (g !== e)
            fail_msg($sformatf("bus %h, expected %h", g, e));
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [RA_W-1:0] a, input logic [DW-1:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [RA_W-1:0] a, input logic [DW-1:0] e);
        word_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_acc();
        rd(REG_ACC_LO, acc[15:0]);
        rd(REG_ACC_HI, acc[31:16]);
    endtask
    task automatic exp_bus(input logic io, input logic [DW-1:0] a,
        input logic [DW-1:0] v);
        bus_q.push_back(dsa_bus_t'{1'b0, 1'b0, ~io, ~a, v});
    endtask
    // Operand doubles as immediate and aux value; address is its inverse
    task automatic op(input dsa_op_t o, input logic [DW-1:0] v,
        input logic [3:0] s, input logic c);
        logic r;
        cmd <= dsa_cmd_t'{o, v, v, v, s, ~v, c};
        cmd_valid <= 1'b1;
        do
        begin
            @(negedge clk);
            r = cmd_ready;
            @(posedge clk);
        end
        while (r !== 1'b1);
        cmd_valid <= 1'b0;
        do
            @(negedge clk);
        while (cmd_ready !== 1'b1);
        @(posedge clk);
    endtask

    // ****
    // Watcher and timeout
    // ****
    always @(posedge clk)
    begin
        rd_d <= reg_rd;
        cyc <= cyc + 1;
        if (cyc > 20000)
        begin
            fail_msg("timeout");
            stop_test();
        end
    end
    always @(negedge clk)
    begin
        if (rd_d)
            chk_word(word_q.pop_front(), reg_rdata);
        if (seen === 1'b1)
            chk_bus(bus_q.pop_front(), seen_bus);
        if (pc_load === 1'b1)
            chk_word(pc_q.size() ? pc_q.pop_front() : ~program_counter,
                program_counter);
    end

    initial
    begin
        void'($urandom(76));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        st = 16'h0018;
        rd(REG_STATUS, st);
        rd(4'hF, 16'h0000);
        chk_word(16'h0001, {15'h0, external_flag});
        acc = $urandom;
        wr(REG_ACC_LO, acc[15:0]);
        wr(REG_ACC_HI, acc[31:16]);
        for (i = 0; i < 4; i++)
        begin
            d = $urandom;
            sh = (i == 3) ? 4'hF : 4'($urandom);
            op(i[0] ? OP_OR_IMM : OP_OR_MEM, d, sh, 1'b0);
            acc = acc | ({16'h0, d} << sh);
            rd_acc();
        end
        $display("test or finished");
        st = 16'h0019;
        wr(REG_STATUS, st);
        for (i = 0; i < 4; i++)
        begin
            op(i[0] ? OP_ROT_RIGHT : OP_ROT_LEFT, 16'h0, 4'h0, 1'b0);
            if (i[0])
                {acc, st[0]} = {st[0], acc};
            else
                {st[0], acc} = {acc, st[0]};
            rd_acc();
            rd(REG_STATUS, st);
        end
        $display("test rotate finished");
        for (i = 0; i < 4; i++)
        begin
            p = $urandom;
            p[31] = i[0];
            wr(REG_PROD_LO, p[15:0]);
            wr(REG_PROD_HI, p[31:16]);
            st[6:5] = i[1:0];
            wr(REG_STATUS, st);
            op(OP_PRODUCT_TO_ACC, 16'h0, 4'h0, 1'b0);
            if (i == 3)
                acc = $signed(p) >>> 6;
            else
                acc = p << (i == 2 ? 4 : i);
            rd_acc();
        end
        $display("test product finished");
        d = $urandom;
        op(OP_MEM_ONTO_STACK, d, 4'h0, 1'b0);
        rd(REG_STACK_TOP, d);
        op(OP_LOW_ACC_ONTO_STACK, 16'h0, 4'h0, 1'b0);
        rd(REG_STACK_TOP, acc[15:0]);
        op(OP_STACK_TO_LOW_ACC, 16'h0, 4'h0, 1'b0);
        acc = {16'h0, acc[15:0]};
        rd_acc();
        rd(REG_STACK_TOP, d);
        pc_q.push_back(d);
        op(OP_SUB_EXIT, 16'h0, 4'h0, 1'b0);
        rd(REG_PC, d);
        d = $urandom;
        op(OP_MEM_ONTO_STACK, d, 4'h0, 1'b0);
        op(OP_COND_EXIT, 16'h0, 4'h0, 1'b0);
        rd(REG_STACK_TOP, d);
        pc_q.push_back(d);
        op(OP_COND_EXIT, 16'h0, 4'h0, 1'b1);
        op(OP_MEM_ONTO_STACK, d, 4'h0, 1'b0);
        exp_bus(1'b0, 16'h1234, d);
        op(OP_STACK_TO_MEM, 16'h1234, 4'h0, 1'b0);
        $display("test stack finished");
        st[4:0] = 5'h1F;
        wr(REG_STATUS, st);
        for (i = 0; i < 5; i++)
        begin
            op(dsa_op_t'(OP_CLR_CARRY + i), 16'h0, 4'h0, 1'b0);
            st[i] = 1'b0;
            rd(REG_STATUS, st);
        end
        rd_acc();
        chk_word(16'h0000, {15'h0, external_flag});
        $display("test clear finished");
        for (i = 0; i < 4; i++)
        begin
            d = $urandom;
            sh = i[0] ? 4'h7 : 4'($urandom_range(7));
            p = acc << sh[2:0];
            exp_bus(i == 0, d, i == 1 ? p[31:16] : i == 2 ? p[15:0] : d);
            op(bops[i], d, sh, 1'b0);
        end
        rd_acc();
        $display("test write cycle finished");
        op(OP_RPT_SHORT, 16'h0002, 4'h0, 1'b0);
        d = $urandom;
        repeat (3) exp_bus(1'b0, d, d);
        op(OP_STORE_AUX, d, 4'h0, 1'b0);
        op(OP_RPT_MEM, 16'hFF01, 4'h0, 1'b0);
        op(OP_ROT_LEFT, 16'h0, 4'h0, 1'b0);
        repeat (2) {st[0], acc} = {acc, st[0]};
        op(OP_RPT_IMM, 16'h0101, 4'h0, 1'b0);
        op(OP_ROT_RIGHT, 16'h0, 4'h0, 1'b0);
        repeat (258) {acc, st[0]} = {st[0], acc};
        st[1] = 1'b1;
        wr(REG_STATUS, st);
        op(OP_RPT_SHORT, 16'h0001, 4'h0, 1'b0);
        op(OP_CLR_TEST, 16'h0, 4'h0, 1'b0);
        st[1] = 1'b0;
        rd_acc();
        rd(REG_STATUS, st);
        $display("test repeat finished");
        stop_test();
    end
endmodule
`default_nettype wire
